// ===== mie_pkg.sv
package mie_pkg;
    localparam logic [11:0] MIE_OFF_MASK = 12'h028;
    localparam logic [11:0] MIE_OFF_PEND = 12'h02C;
    localparam int MIE_BIT_LINK = 31;
    localparam int MIE_BIT_TXDONE = 30;
    localparam int MIE_BIT_RXDONE = 29;
    localparam int MIE_BIT_TXUNAV = 28;
    localparam int MIE_BIT_RXUNAV = 27;
    localparam int MIE_BIT_TXSTOP = 26;
    localparam int MIE_BIT_RXSTOP = 25;
    localparam int MIE_BIT_LOW = 25;
    localparam int MIE_NUM_EVT = 7;
    localparam logic [6:0] MIE_MASK_RESET = 7'h00;
    localparam logic [6:0] MIE_PEND_RESET = 7'h00;
    localparam logic [31:0] MIE_ZERO_WORD = 32'h00000000;
endpackage

// ===== mie_properties.sv
`timescale 1ns/10ps
module mie_checker
    import mie_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic tx_desc_host_owned,
    input wire logic tx_suspend,
    input wire logic cpu_irq
);
    wire acc = psel && penable;
    wire hit = paddr == MIE_OFF_MASK || paddr == MIE_OFF_PEND;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reserved_zero_a: assert property (acc && !pwrite |-> !(|prdata[24:0]))
        else $error("reserved bits not zero");
    suspend_rise_a: assert property ($rose(tx_desc_host_owned) |=> tx_suspend)
        else $error("suspend missing");
    suspend_fall_a: assert property ($fell(tx_desc_host_owned) |=> !tx_suspend)
        else $error("suspend stuck");
    mask_off_a: assert property (acc && pwrite && paddr == MIE_OFF_MASK
        && pstrb[3] && pwdata[31:25] == 7'h00 |=> ##1 !cpu_irq)
        else $error("interrupt kept after full mask");
    unmapped_err_a: assert property (acc && !hit |-> pslverr)
        else $error("no error on unmapped");
    unmapped_zero_a: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    err_phase_a: assert property (pslverr |-> acc)
        else $error("error outside access");
    irq_stay_a: assert property (acc && !pwrite && cpu_irq |=> cpu_irq)
        else $error("read dropped interrupt");
    cover property ($rose(cpu_irq));
    cover property (acc && pslverr);
    cover property ($rose(tx_suspend));
endmodule
bind mie_top mie_checker mie_checker_inst (.*);

// ===== mie_sticky.sv
`timescale 1ns/10ps
// One sticky pending bit: set on an event edge, cleared by writing one.
module mie_sticky (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic evt,
    input wire logic clr,
    output logic pending
);
    logic evt_q;
    logic rise;
    logic next_pending;

    assign rise = evt & ~evt_q;
    // A rise in the clearing cycle wins over the clear.
    assign next_pending = rise | (pending & ~clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= 1'b0;
            pending <= 1'b0;
        end else begin
            evt_q <= evt;
            pending <= next_pending;
        end
    end
endmodule

// ===== mie_top.sv
`timescale 1ns/10ps
// Operation
// - Mask bit 31 enables link-change interrupt; resets to zero.
// - Mask bit 30 enables frame-transmitted interrupt; resets to zero.
// - Mask bit 29 enables frame-received interrupt; resets to zero.
// - Mask bit 28 enables transmit-descriptor-unavailable interrupt; resets zero.
// - Mask bit 27 enables receive-descriptor-unavailable interrupt; resets zero.
// - Mask bit 26 enables transmit-stopped interrupt; resets to zero.
// - Mask bit 25 enables receive-stopped interrupt; resets to zero.
// - Interrupt the CPU while any pending bit and its enable are set.
// - Reading the pending register changes nothing.
// - Pending bit 31 sets on any link state change, up or down.
// - Pending bits set on event edges; writing one clears, zero keeps.
// - Pending bit 30 sets when a frame was sent and more accepted.
// - Pending bit 29 sets when a received frame awaits the host.
// - Pending bit 28 sets when the next transmit descriptor is host-owned.
// - Pending bit 27 sets only on first unowned receive descriptor.
module mie_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_up,
    input wire logic tx_done_evt,
    input wire logic rx_done_evt,
    input wire logic tx_desc_host_owned,
    input wire logic rx_desc_fetch,
    input wire logic rx_desc_dev_owned,
    input wire logic tx_stopped,
    input wire logic rx_stopped,
    output logic tx_suspend,
    output logic cpu_irq
);
    import mie_pkg::*;

    logic [6:0] interrupt_mask_reg;
    logic [6:0] interrupt_pending_reg;
    logic [6:0] evt_vec;
    logic [6:0] clr_vec;
    logic link_s1;
    logic link_s2;
    logic link_q;
    logic rx_prev_owned;
    logic rx_unav_evt;
    logic next_rx_prev_owned;
    logic next_tx_suspend;
    logic link_toggle;
    logic [31:0] next_prdata;

    wire access = psel & penable;
    wire sel_mask = (paddr == MIE_OFF_MASK);
    wire sel_pend = (paddr == MIE_OFF_PEND);
    wire hit = sel_mask | sel_pend;
    wire wr_mask = access & pwrite & sel_mask & pstrb[3];
    wire wr_pend = access & pwrite & sel_pend & pstrb[3];

    wire link_change_irq_en = interrupt_mask_reg[6];
    wire tx_done_irq_en = interrupt_mask_reg[5];
    wire rx_done_irq_en = interrupt_mask_reg[4];
    wire tx_desc_unavail_irq_en = interrupt_mask_reg[3];
    wire rx_desc_unavail_irq_en = interrupt_mask_reg[2];
    wire tx_stopped_irq_en = interrupt_mask_reg[1];
    wire rx_stopped_irq_en = interrupt_mask_reg[0];

    wire link_change_pending = interrupt_pending_reg[6];
    wire tx_done_pending = interrupt_pending_reg[5];
    wire rx_done_pending = interrupt_pending_reg[4];
    wire tx_desc_unavail_pending = interrupt_pending_reg[3];
    wire rx_desc_unavail_pending = interrupt_pending_reg[2];

    // Places the seven event bits at the top of a 32-bit word.
    function automatic logic [31:0] place_top(input logic [6:0] v);
        place_top = {v, 25'h0000000};
    endfunction

    assign pready = 1'b1;
    assign pslverr = access & ~hit;

    // Link change is a level toggle; it becomes a pulse on either edge.
    assign link_toggle = link_s2 ^ link_q;
    // Unavailable receive descriptor flagged only after a device-owned one or after reset.
    assign rx_unav_evt = rx_desc_fetch & ~rx_desc_dev_owned
        & rx_prev_owned;
    assign next_rx_prev_owned = rx_desc_fetch ? rx_desc_dev_owned
        : rx_prev_owned;
    // Transmit suspends on a host-owned descriptor until it is released.
    assign next_tx_suspend = tx_desc_host_owned;

    assign evt_vec = {link_toggle, tx_done_evt, rx_done_evt,
        tx_desc_host_owned, rx_unav_evt, tx_stopped, rx_stopped};
    // Write one to clear; zero bits leave the pending bit alone.
    assign clr_vec = wr_pend ? pwdata[31:25] : 7'h00;

    assign next_prdata = sel_mask ? place_top(interrupt_mask_reg)
        : sel_pend ? place_top(interrupt_pending_reg)
        : MIE_ZERO_WORD;

    genvar gi;
    generate
        for (gi = 0; gi < MIE_NUM_EVT; gi = gi + 1) begin : g_evt
            mie_sticky u_sticky (
                .pclk(pclk),
                .presetn(presetn),
                .evt(evt_vec[gi]),
                .clr(clr_vec[gi]),
                .pending(interrupt_pending_reg[gi])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            link_q <= 1'b0;
        end else begin
            link_s1 <= link_up;
            link_s2 <= link_s1;
            link_q <= link_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_mask_reg <= MIE_MASK_RESET;
        end else if (wr_mask) begin
            interrupt_mask_reg <= pwdata[31:25];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_owned <= 1'b1;
            tx_suspend <= 1'b0;
        end else begin
            rx_prev_owned <= next_rx_prev_owned;
            tx_suspend <= next_tx_suspend;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= MIE_ZERO_WORD;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_irq <= 1'b0;
        end else begin
            cpu_irq <= |(interrupt_mask_reg & interrupt_pending_reg);
        end
    end
endmodule

// ===== mie_top_bench.sv
`timescale 1ns/10ps
module mie_top_bench;
    import mie_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, own = 1'b0, pready, pslverr, tx_suspend, cpu_irq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, ex;
    logic [3:0] pstrb = 4'hF;
    logic [6:0] ev = 7'h00;
    int fails = 0, check_count = 0;
    always #50 pclk = ~pclk;
    mie_top mie_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_up(ev[6]), .tx_done_evt(ev[5]), .rx_done_evt(ev[4]),
        .tx_desc_host_owned(ev[3]), .rx_desc_fetch(ev[2]),
        .rx_desc_dev_owned(own), .tx_stopped(ev[1]), .rx_stopped(ev[0]),
        .tx_suspend(tx_suspend), .cpu_irq(cpu_irq));
    function automatic logic [31:0] vis(input logic [31:0] m);
        return m & 32'hFE000000;
    endfunction
    task complete_run;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) begin
            fails++;
            complete_run;
        end
        rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    task pulse(input int i);
        @(posedge pclk) ev[i] <= 1'b1;
        @(posedge pclk) ev[i] <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask
    initial begin
        void'($urandom(32'h0B74));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, MIE_OFF_MASK, 0); chk("mask", 0, rd);
        apb(0, MIE_OFF_PEND, 0); chk("pend", 0, rd);
        for (int k = 0; k < 4; k++) begin
            ex = $urandom;
            apb(1, MIE_OFF_MASK, ex);
            apb(0, MIE_OFF_MASK, 0); chk("mask", vis(ex), rd);
        end
        apb(1, MIE_OFF_MASK, 32'hFFFFFFFF);
        ex = 0;
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            ex[25+i] = 1'b1;
            apb(0, MIE_OFF_PEND, 0); chk("pend", ex, rd);
            chk("irq", 1, cpu_irq);
        end
        apb(1, MIE_OFF_PEND, 0);
        apb(0, MIE_OFF_PEND, 0); chk("pend", ex, rd);
        apb(1, MIE_OFF_PEND, ex);
        apb(0, MIE_OFF_PEND, 0); chk("pend", 0, rd);
        chk("irq", 0, cpu_irq);
        pulse(2);
        apb(0, MIE_OFF_PEND, 0); chk("pend", 0, rd);
        own <= 1'b1;
        pulse(2);
        own <= 1'b0;
        pulse(2);
        apb(0, MIE_OFF_PEND, 0); chk("pend", 32'h08000000, rd);
        apb(1, MIE_OFF_MASK, 0);
        pulse(5); chk("irq", 0, cpu_irq);
        pstrb <= 4'h7;
        apb(1, MIE_OFF_MASK, 32'hFFFFFFFF);
        pstrb <= 4'hF;
        apb(0, MIE_OFF_MASK, 0); chk("mask", 0, rd);
        apb(0, 12'h030, 0); chk("err", 1, er);
        chk("bad", 0, rd);
        complete_run;
    end
endmodule
